// ==== design/dmab_pkg.sv ====
`default_nettype none
package dmab_pkg;
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_SEL  = 4'h4;
	localparam logic [3:0] ADR_STAT = 4'h8;
	localparam int CT_TYPE = 0;
	localparam int CT_WID  = 2;
	localparam int CT_SGN  = 4;
	localparam int CT_SUB  = 5;
	localparam int CT_SHF  = 6;
	localparam int CT_DYN  = 7;
	localparam int CT_INEN = 8;
	localparam int CT_PPEN = 9;
	localparam int CT_OUEN = 10;
	localparam int SS_CLK  = 0;
	localparam int SS_CE   = 2;
	localparam int SS_RST  = 4;
	localparam int SS_W    = 6;
	localparam int ST_ERR  = 0;
	localparam int ST_CNT  = 1;
	localparam int ST_OVF  = 5;
	localparam logic [10:0] CTRL_RST = 11'h000;
	localparam logic [17:0] SEL_RST  = 18'h00000;
	localparam int OPW  = 72;
	localparam int PW   = 74;
	localparam int ACCW = 72;
	localparam int RESW = 144;

	typedef enum logic [1:0] {ET_PLAIN, ET_MAC, ET_PAIR, ET_QUAD} dmab_elem_t;
	typedef enum logic [1:0] {WD_9, WD_18, WD_36, WD_BAD} dmab_wid_t;

	// elements per block; zero marks an unsupported pairing
	function automatic logic [3:0] elem_count(dmab_elem_t et,
			dmab_wid_t wd);
		logic [3:0] n;
		n = 4'h0;
		unique case (et)
		ET_PLAIN: n = (wd == WD_9) ? 4'h8 : (wd == WD_18) ? 4'h4 :
				(wd == WD_36) ? 4'h1 : 4'h0;
		ET_MAC:   n = (wd == WD_9 || wd == WD_18) ? 4'h2 : 4'h0;
		ET_PAIR:  n = (wd == WD_9) ? 4'h4 : (wd == WD_18) ? 4'h2 : 4'h0;
		ET_QUAD:  n = (wd == WD_9) ? 4'h2 : (wd == WD_18) ? 4'h1 : 4'h0;
		endcase
		return n;
	endfunction : elem_count

	function automatic logic [31:0] wb_merge(logic [31:0] old,
			logic [31:0] dat, logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				r[8*i +: 8] = dat[8*i +: 8];
		end
		return r;
	endfunction : wb_merge
endpackage : dmab_pkg
`default_nettype wire

// ==== design/dmab_mul.sv ====
`default_nettype none
module dmab_mul
	import dmab_pkg::*;
#(
	parameter int W = 9
) (
	input  wire logic [W-1:0]  a_i,
	input  wire logic [W-1:0]  b_i,
	input  wire logic          sgn_i,
	output logic      [PW-1:0] p_o
);
	logic signed [W:0]     a_x;
	logic signed [W:0]     b_x;
	logic signed [2*W+1:0] p_x;

	// one sign mode for both operands
	assign a_x = {sgn_i & a_i[W-1], a_i};
	assign b_x = {sgn_i & b_i[W-1], b_i};
	assign p_x = a_x * b_x;
	assign p_o = PW'(p_x);
endmodule : dmab_mul
`default_nettype wire

// ==== design/dmab_stage_ctl.sv ====
`default_nettype none
module dmab_stage_ctl
	import dmab_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic [SS_W-1:0] sel_i,
	input  wire logic [3:0]      clk_src_i,
	input  wire logic [3:0]      ce_src_i,
	input  wire logic [3:0]      rst_src_i,
	output logic                 step_o,
	output logic                 clr_o
);
	logic [3:0] prev_reg;
	logic [1:0] cs;
	logic [1:0] es;
	logic [1:0] rs;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			prev_reg <= 4'hf;
		else
			prev_reg <= clk_src_i;
	end

	assign cs = sel_i[SS_CLK +: 2];
	assign es = sel_i[SS_CE +: 2];
	assign rs = sel_i[SS_RST +: 2];
	// stage advances on a rising edge of its chosen source
	assign step_o = clk_src_i[cs] & ~prev_reg[cs] & ce_src_i[es];
	assign clr_o  = rst_src_i[rs];
endmodule : dmab_stage_ctl
`default_nettype wire

// ==== design/dmab_top.sv ====
// Function
// - four element types at 9, 18 or 36 bit operand width
// - one signedness shared by every operand of an element
// - one operand width for all elements of the block
// - plain products: eight at x9, four at x18, one at x36
// - MAC 2/2, paired 4/2, quad 2/1 at x9/x18, none at x36
// - input registers load in parallel or shift from previous lane
// - dynamic mode switches signedness on any cycle
// - dynamic mode switches accumulator add or subtract any cycle
// - dynamic mode switches parallel or serial operand loading
// - plain element outputs A times B, input and pipeline registers optional, output always registered
// - MAC adds each product into the output register, always clocked by its stage
// - accumulator can be reloaded with a new start at run time
// - paired element gives A0*B0 plus or minus A1*B1
// - quad element sums two paired add or subtract results
// - each stage picks its clock from four sources
// - each stage picks enable and reset from four sources each
// - overflow on unsigned wrap or signed sign flip
// - overflow output is a registered one cycle pulse per event
`default_nettype none
module dmab_top
	import dmab_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [3:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic            dsp_clock_src_0_i,
	input  wire logic            dsp_clock_src_1_i,
	input  wire logic            dsp_clock_src_2_i,
	input  wire logic            dsp_clock_src_3_i,
	input  wire logic            dsp_enable_src_0_i,
	input  wire logic            dsp_enable_src_1_i,
	input  wire logic            dsp_enable_src_2_i,
	input  wire logic            dsp_enable_src_3_i,
	input  wire logic            dsp_reset_src_0_i,
	input  wire logic            dsp_reset_src_1_i,
	input  wire logic            dsp_reset_src_2_i,
	input  wire logic            dsp_reset_src_3_i,
	input  wire logic [OPW-1:0]  opa_i,
	input  wire logic [OPW-1:0]  opb_i,
	input  wire logic            sign_dyn_i,
	input  wire logic            addsub_dyn_i,
	input  wire logic            shift_dyn_i,
	input  wire logic            acc_init_i,
	output logic      [RESW-1:0] result_o,
	output logic      [1:0]      overflow_o
);
	logic [10:0]     ctrl_reg;
	logic [17:0]     sel_reg;
	logic [1:0]      seen_reg;
	logic            ack_reg;
	logic [31:0]     rdat_reg;
	dmab_elem_t      et;
	dmab_wid_t       wd;
	logic [3:0]      cnt;
	logic            cfg_err;
	logic            is_mac;
	logic            wb_req;
	logic            wb_wr;
	logic            sgn_c;
	logic            sub_c;
	logic            shf_c;
	logic [3:0]      clk_src;
	logic [3:0]      ce_src;
	logic [3:0]      rst_src;
	logic [2:0]      step;
	logic [2:0]      clr;
	logic [OPW-1:0]  a_reg;
	logic [OPW-1:0]  b_reg;
	logic [OPW-1:0]  a_u;
	logic [OPW-1:0]  b_u;
	logic            sgn_r;
	logic            sub_r;
	logic            ini_r;
	logic            sgn_m;
	logic            sub_m;
	logic            ini_m;
	logic            sgn_p;
	logic            sub_p;
	logic            ini_p;
	logic            sgn_u;
	logic            sub_u;
	logic            ini_u;
	logic [PW-1:0]   p9 [8];
	logic [PW-1:0]   p18 [4];
	logic [PW-1:0]   p36;
	logic [PW-1:0]   pn [8];
	logic [PW-1:0]   pr_reg [8];
	logic [PW-1:0]   pu [8];
	logic [PW-1:0]   v [8];
	logic [ACCW-1:0] acc [2];
	logic [ACCW-1:0] add [2];
	logic [ACCW-1:0] acc_n [2];
	logic [1:0]      ovf_c;
	logic [1:0]      ovf_reg;
	logic [RESW-1:0] res_c;
	logic [RESW-1:0] res_reg;
	logic            upd;

	function automatic logic [OPW-1:0] shl(logic [OPW-1:0] r,
			logic [OPW-1:0] d, dmab_wid_t w);
		unique case (w)
		WD_9:    return {r[OPW-10:0], d[8:0]};
		WD_18:   return {r[OPW-19:0], d[17:0]};
		default: return {r[OPW-37:0], d[35:0]};
		endcase
	endfunction : shl

	function automatic logic [PW-1:0] pm(logic [PW-1:0] x,
			logic [PW-1:0] y, logic s);
		return s ? x - y : x + y;
	endfunction : pm

	// configuration and status
	assign et      = dmab_elem_t'(ctrl_reg[CT_TYPE +: 2]);
	assign wd      = dmab_wid_t'(ctrl_reg[CT_WID +: 2]);
	assign cnt     = elem_count(et, wd);
	assign cfg_err = (cnt == 4'h0);
	assign is_mac  = (et == ET_MAC) && !cfg_err;
	assign sgn_c   = ctrl_reg[CT_DYN] ? sign_dyn_i : ctrl_reg[CT_SGN];
	assign sub_c   = ctrl_reg[CT_DYN] ? addsub_dyn_i : ctrl_reg[CT_SUB];
	assign shf_c   = ctrl_reg[CT_DYN] ? shift_dyn_i : ctrl_reg[CT_SHF];

	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= wb_req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdat_reg <= 32'h00000000;
		else if (wb_req) begin
			unique case (wb_adr_i)
			ADR_CTRL: rdat_reg <= 32'(ctrl_reg);
			ADR_SEL:  rdat_reg <= 32'(sel_reg);
			ADR_STAT: rdat_reg <= 32'({seen_reg, cnt, cfg_err});
			default:  rdat_reg <= 32'h00000000;
			endcase
		end
	end

	// writes land on the edge where the master sees ack
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl_reg <= CTRL_RST;
		else if (wb_wr && wb_adr_i == ADR_CTRL)
			ctrl_reg <= 11'(wb_merge(32'(ctrl_reg), wb_dat_i, wb_sel_i));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			sel_reg <= SEL_RST;
		else if (wb_wr && wb_adr_i == ADR_SEL)
			sel_reg <= 18'(wb_merge(32'(sel_reg), wb_dat_i, wb_sel_i));
	end

	// sticky overflow record; a new pulse beats a clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			seen_reg <= 2'b00;
		else if (wb_wr && wb_adr_i == ADR_STAT && wb_sel_i[0])
			seen_reg <= (seen_reg & ~wb_dat_i[ST_OVF +: 2]) | ovf_reg;
		else
			seen_reg <= seen_reg | ovf_reg;
	end

	// stage clock, enable and reset selection
	assign clk_src = {dsp_clock_src_3_i, dsp_clock_src_2_i,
			dsp_clock_src_1_i, dsp_clock_src_0_i};
	assign ce_src  = {dsp_enable_src_3_i, dsp_enable_src_2_i,
			dsp_enable_src_1_i, dsp_enable_src_0_i};
	assign rst_src = {dsp_reset_src_3_i, dsp_reset_src_2_i,
			dsp_reset_src_1_i, dsp_reset_src_0_i};

	for (genvar s = 0; s < 3; s++) begin : g_stage
		dmab_stage_ctl u_ctl (
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.sel_i     (sel_reg[SS_W*s +: SS_W]),
			.clk_src_i (clk_src),
			.ce_src_i  (ce_src),
			.rst_src_i (rst_src),
			.step_o    (step[s]),
			.clr_o     (clr[s])
		);
	end

	// input stage
	always_ff @(posedge clk_i) begin
		if (rst_i || clr[0]) begin
			a_reg <= '0;
			b_reg <= '0;
			sgn_r <= 1'b0;
			sub_r <= 1'b0;
			ini_r <= 1'b0;
		end else if (step[0]) begin
			a_reg <= shf_c ? shl(a_reg, opa_i, wd) : opa_i;
			b_reg <= shf_c ? shl(b_reg, opb_i, wd) : opb_i;
			sgn_r <= sgn_c;
			sub_r <= sub_c;
			ini_r <= acc_init_i;
		end
	end

	assign a_u   = ctrl_reg[CT_INEN] ? a_reg : opa_i;
	assign b_u   = ctrl_reg[CT_INEN] ? b_reg : opb_i;
	assign sgn_m = ctrl_reg[CT_INEN] ? sgn_r : sgn_c;
	assign sub_m = ctrl_reg[CT_INEN] ? sub_r : sub_c;
	assign ini_m = ctrl_reg[CT_INEN] ? ini_r : acc_init_i;

	// multiplier lanes for each width
	for (genvar i = 0; i < 8; i++) begin : g_m9
		dmab_mul #(.W(9)) u_mul (
			.a_i   (a_u[9*i +: 9]),
			.b_i   (b_u[9*i +: 9]),
			.sgn_i (sgn_m),
			.p_o   (p9[i])
		);
	end
	for (genvar i = 0; i < 4; i++) begin : g_m18
		dmab_mul #(.W(18)) u_mul (
			.a_i   (a_u[18*i +: 18]),
			.b_i   (b_u[18*i +: 18]),
			.sgn_i (sgn_m),
			.p_o   (p18[i])
		);
	end
	dmab_mul #(.W(36)) u_m36 (
		.a_i   (a_u[35:0]),
		.b_i   (b_u[35:0]),
		.sgn_i (sgn_m),
		.p_o   (p36)
	);

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			unique case (wd)
			WD_9:    pn[i] = p9[i];
			WD_18:   pn[i] = (i < 4) ? p18[i % 4] : '0;
			default: pn[i] = (i == 0) ? p36 : '0;
			endcase
		end
	end

	// pipeline stage
	always_ff @(posedge clk_i) begin
		if (rst_i || clr[1]) begin
			for (int i = 0; i < 8; i++)
				pr_reg[i] <= '0;
			sgn_p <= 1'b0;
			sub_p <= 1'b0;
			ini_p <= 1'b0;
		end else if (step[1]) begin
			pr_reg <= pn;
			sgn_p  <= sgn_m;
			sub_p  <= sub_m;
			ini_p  <= ini_m;
		end
	end

	always_comb begin
		for (int i = 0; i < 8; i++)
			pu[i] = ctrl_reg[CT_PPEN] ? pr_reg[i] : pn[i];
	end
	assign sgn_u = ctrl_reg[CT_PPEN] ? sgn_p : sgn_m;
	assign sub_u = ctrl_reg[CT_PPEN] ? sub_p : sub_m;
	assign ini_u = ctrl_reg[CT_PPEN] ? ini_p : ini_m;

	// accumulators live in the output register
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			acc[k] = res_reg[ACCW*k +: ACCW];
			add[k] = sub_u ? ACCW'(-pu[k]) : pu[k][ACCW-1:0];
			acc_n[k] = ini_u ? add[k] : acc[k] + add[k];
			if (ini_u)
				ovf_c[k] = 1'b0;
			else if (sgn_u)
				ovf_c[k] = (acc[k][ACCW-1] == add[k][ACCW-1]) &&
						(acc_n[k][ACCW-1] != acc[k][ACCW-1]);
			else if (sub_u)
				ovf_c[k] = pu[k][ACCW-1:0] > acc[k];
			else
				ovf_c[k] = acc_n[k] < acc[k];
		end
	end

	// element results packed into equal slots
	always_comb begin
		for (int k = 0; k < 8; k++)
			v[k] = pu[k];
		unique case (et)
		ET_MAC: begin
			for (int k = 0; k < 2; k++)
				v[k] = {2'b00, acc_n[k]};
		end
		ET_PAIR: begin
			for (int k = 0; k < 4; k++)
				v[k] = pm(pu[2*k], pu[2*k+1], sub_u);
		end
		ET_QUAD: begin
			for (int k = 0; k < 2; k++)
				v[k] = pm(pu[4*k], pu[4*k+1], sub_u) +
						pm(pu[4*k+2], pu[4*k+3], sub_u);
		end
		default: ;
		endcase
		res_c = '0;
		if (!cfg_err) begin
			for (int k = 0; k < 8; k++) begin
				case (cnt)
				4'h8: res_c[18*k +: 18] = v[k][17:0];
				4'h4: if (k < 4) res_c[36*k +: 36] = v[k][35:0];
				4'h2: if (k < 2) res_c[72*k +: 72] = v[k][71:0];
				default: if (k == 0) res_c = {{70{v[0][PW-1]}}, v[0]};
				endcase
			end
		end
	end

	// output stage; always clocked by its stage for the accumulator
	assign upd = (is_mac || ctrl_reg[CT_OUEN]) ? step[2] : 1'b1;

	always_ff @(posedge clk_i) begin
		if (rst_i || clr[2])
			res_reg <= '0;
		else if (upd)
			res_reg <= res_c;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || clr[2])
			ovf_reg <= 2'b00;
		else
			ovf_reg <= (upd && is_mac) ? ovf_c : 2'b00;
	end

	assign result_o   = res_reg;
	assign overflow_o = ovf_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ovf_cause: assert property (
		overflow_o[0] |-> $past(upd) && $past(is_mac) && !$past(ini_u))
		else $error("overflow pulse without accumulate step");
	a_ovf_single: assert property (
		!upd |=> overflow_o == 2'b00)
		else $error("overflow held without new step");
	a_acc_add: assert property (
		upd && is_mac && !ini_u && !clr[2] |=>
		res_reg[ACCW-1:0] == $past(acc[0]) + $past(add[0]))
		else $error("accumulator did not add product");
	a_acc_init: assert property (
		upd && is_mac && ini_u && !clr[2] |=>
		res_reg[ACCW-1:0] == $past(add[0]))
		else $error("accumulator not reloaded");
	a_ovf_uadd: assert property (
		upd && is_mac && !sgn_u && !sub_u && !ini_u && !clr[2] &&
		(acc[0] + add[0] < acc[0]) |=> overflow_o[0])
		else $error("unsigned wrap not flagged");
	a_ovf_signed: assert property (
		upd && is_mac && sgn_u && !ini_u && !clr[2] &&
		!acc[0][ACCW-1] && !add[0][ACCW-1] && acc_n[0][ACCW-1]
		|=> overflow_o[0])
		else $error("signed overflow not flagged");
	a_shift_load: assert property (
		step[0] && !clr[0] && shf_c && wd == WD_9 |=>
		a_reg[OPW-1:9] == $past(a_reg[OPW-10:0]) &&
		a_reg[8:0] == $past(opa_i[8:0]))
		else $error("serial load did not shift");
	a_stage_hold: assert property (
		!step[0] && !clr[0] |=> $stable(a_reg) && $stable(b_reg))
		else $error("input stage moved without its enable");
	a_clr_stage: assert property (
		clr[2] |=> result_o == '0 && overflow_o == 2'b00)
		else $error("output stage ignored its reset");
	a_plain_x9: assert property (
		upd && !clr[2] && et == ET_PLAIN && wd == WD_9 && !sgn_c &&
		!ctrl_reg[CT_INEN] && !ctrl_reg[CT_PPEN] |=>
		result_o[17:0] == 18'($past(opa_i[8:0]) * $past(opb_i[8:0])))
		else $error("plain product wrong");
	a_illegal_zero: assert property (
		upd && cfg_err && !clr[2] |=> result_o == '0)
		else $error("unsupported element produced data");

	c_mac_ovf: cover property (overflow_o[0]);
	c_shift: cover property (step[0] && shf_c);
	c_quad: cover property (upd && et == ET_QUAD && !cfg_err);
endmodule : dmab_top
`default_nettype wire

// ==== dv/dmab_fabric.sv ====
`default_nettype none
module dmab_fabric (
	input  wire logic [31:0] na_i,
	input  wire logic [31:0] nb_i,
	input  wire logic        sgn_i,
	input  wire logic        w18_i,
	output logic      [71:0] opa_o,
	output logic      [71:0] opb_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// short fabric values are widened to a full lane
	function automatic logic [17:0] widen(logic [3:0] v, logic s);
		return {{14{s & v[3]}}, v};
	endfunction : widen

	always_comb begin
		opa_o = '0;
		opb_o = '0;
		for (int i = 0; i < 8; i++) begin
			if (w18_i && i < 4) begin
				opa_o[18*i +: 18] = widen(na_i[4*i +: 4], sgn_i);
				opb_o[18*i +: 18] = widen(nb_i[4*i +: 4], sgn_i);
			end else if (!w18_i) begin
				opa_o[9*i +: 9] = 9'(widen(na_i[4*i +: 4], sgn_i));
				opb_o[9*i +: 9] = 9'(widen(nb_i[4*i +: 4], sgn_i));
			end
		end
	end
endmodule : dmab_fabric
`default_nettype wire

// ==== dv/test_dsp_multiply_accumulate_block.sv ====
`default_nettype none
module test_dsp_multiply_accumulate_block
	import dmab_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {int due; logic [RESW-1:0] v; logic [1:0] o;} dmab_exp_t;
	localparam logic [63:0] CNT = 64'h0012_0024_0022_0148;

	logic            clk_i = 1'b0;
	logic            rst_i = 1'b1;
	logic            cyc = 1'b0, stb = 1'b0, we = 1'b0, shf = 1'b0, ack;
	logic [3:0]      adr = '0, sel = '0;
	logic [31:0]     dat = '0, na = '0, nb = '0, rdat;
	logic [3:0]      csrc = '0, esrc = 4'hf, rsrc = '0;
	logic            sgn = 1'b0, addsub = 1'b0, init = 1'b0, w18 = 1'b0;
	logic [OPW-1:0]  opa, opb;
	logic [RESW-1:0] res, acc;
	logic [1:0]      ovf;
	int              mismatches = 0, n_compared = 0, cyc_n = 0;
	int              seed = 7623;
	logic [31:0]     rq[$];
	dmab_exp_t       dq[$];

	always #5 clk_i = ~clk_i;

	dmab_fabric i_dmab_fabric (.na_i(na), .nb_i(nb), .sgn_i(sgn),
		.w18_i(w18), .opa_o(opa), .opb_o(opb));

	dmab_top i_dmab_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dsp_clock_src_0_i(csrc[0]), .dsp_clock_src_1_i(csrc[1]),
		.dsp_clock_src_2_i(csrc[2]), .dsp_clock_src_3_i(csrc[3]),
		.dsp_enable_src_0_i(esrc[0]), .dsp_enable_src_1_i(esrc[1]),
		.dsp_enable_src_2_i(esrc[2]), .dsp_enable_src_3_i(esrc[3]),
		.dsp_reset_src_0_i(rsrc[0]), .dsp_reset_src_1_i(rsrc[1]),
		.dsp_reset_src_2_i(rsrc[2]), .dsp_reset_src_3_i(rsrc[3]),
		.opa_i(opa), .opb_i(opb), .sign_dyn_i(sgn), .addsub_dyn_i(addsub),
		.shift_dyn_i(shf), .acc_init_i(init), .result_o(res),
		.overflow_o(ovf));

	task automatic report_and_stop;
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task automatic cmp_reg(logic [31:0] got, logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t read %h expected %h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_res(logic [RESW-1:0] got, logic [RESW-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t result %h expected %h", $time, got, exp);
		end
	endtask : cmp_res

	task automatic cmp_ovf(logic [1:0] got, logic [1:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t overflow %b expected %b", $time, got, exp);
		end
	endtask : cmp_ovf

	// one classic cycle; read data is checked by the monitor at ack
	task automatic wb(logic w, logic [3:0] a, logic [31:0] d, logic [31:0] e);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		if (!w)
			rq.push_back(e);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
			cmp_reg(rdat, rq.pop_front());

	// result loads on the edge after the driving edge
	task automatic expect_res(logic [RESW-1:0] v, logic [1:0] o);
		dq.push_back('{cyc_n + 2, v, o});
	endtask : expect_res

	always @(negedge clk_i) begin : res_mon
		dmab_exp_t e;
		cyc_n++;
		while (dq.size() > 0 && dq[0].due <= cyc_n) begin
			e = dq.pop_front();
			cmp_res(res, e.v);
			cmp_ovf(ovf, e.o);
		end
	end

	function automatic longint lv(logic [3:0] v, logic s);
		return s ? longint'(signed'(v)) : longint'(v);
	endfunction : lv

	function automatic logic [RESW-1:0] calc(logic [31:0] a,
			logic [31:0] b, logic s, logic sub, int lanes, int per);
		logic [RESW-1:0] r;
		longint          t;
		int              w;
		r = '0;
		w = RESW * per / lanes;
		for (int k = 0; k < lanes / per; k++) begin
			t = 0;
			for (int j = 0; j < per; j++)
				t += (sub && j % 2 == 1 ? -1 : 1) *
					lv(a[4*(k*per+j) +: 4], s) * lv(b[4*(k*per+j) +: 4], s);
			r |= (RESW'(t) & ~({RESW{1'b1}} << w)) << (w * k);
		end
		return r;
	endfunction : calc

	task automatic burst(int lanes, int per, logic s, logic sub,
			logic rs, logic rsub);
		logic [31:0] a, b;
		logic        sc, subc;
		repeat (8) begin
			a = $random(seed);
			b = $random(seed);
			sc = rs ? 1'($random(seed)) : s;
			subc = rsub ? 1'($random(seed)) : sub;
			@(posedge clk_i);
			na <= a;
			nb <= b;
			sgn <= sc;
			addsub <= subc;
			w18 <= (lanes == 4);
			csrc <= 4'($random(seed));
			esrc <= 4'($random(seed));
			rsrc <= {3'($random(seed)), 1'b0};
			expect_res(calc(a, b, sc, subc, lanes, per), 2'b00);
		end
	endtask : burst

	task automatic mac_step(logic ini, logic en, logic [3:0] src, logic go);
		logic [31:0] a, b;
		a = $random(seed);
		b = $random(seed);
		@(posedge clk_i);
		csrc <= 4'h0;
		@(posedge clk_i);
		na <= a;
		nb <= b;
		init <= ini;
		csrc <= src;
		esrc[0] <= en;
		if (go)
			acc = (ini ? '0 : acc) + calc(a, b, 1'b0, 1'b0, 2, 1);
		expect_res(acc, 2'b00);
	endtask : mac_step

	// one rising edge of the chosen stage source with fixed operands
	task automatic drive_step(logic [31:0] a, logic [31:0] b, logic ini,
			logic sub, logic sh, logic [3:0] src);
		@(posedge clk_i);
		csrc <= 4'h0;
		@(posedge clk_i);
		na <= a;
		nb <= b;
		init <= ini;
		addsub <= sub;
		shf <= sh;
		csrc <= src;
	endtask : drive_step

	initial begin : main
		logic [3:0] c;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, ADR_CTRL, 32'h0, 32'h0);
		wb(1'b0, ADR_SEL, 32'h0, 32'h0);
		wb(1'b0, ADR_STAT, 32'h0, 32'h10);
		wb(1'b1, 4'hc, 32'hffffffff, 32'h0);
		wb(1'b0, 4'hc, 32'h0, 32'h0);
		wb(1'b0, 4'h1, 32'h0, 32'h0);
		wb(1'b1, ADR_SEL, 32'hffffffff, 32'h0);
		wb(1'b0, ADR_SEL, 32'h0, 32'h3ffff);
		wb(1'b1, ADR_SEL, 32'h0, 32'h0);
		wb(1'b1, ADR_CTRL, 32'hffffffff, 32'h0);
		wb(1'b0, ADR_CTRL, 32'h0, 32'h7ff);
		for (int i = 0; i < 16; i++) begin
			wb(1'b1, ADR_CTRL, 32'(i), 32'h0);
			c = CNT[4*{i[1:0], i[3:2]} +: 4];
			wb(1'b0, ADR_STAT, 32'h0, 32'({c, c == 4'h0}));
		end
		wb(1'b1, ADR_CTRL, 32'h0, 32'h0);
		burst(8, 1, 1'b0, 1'b0, 1'b0, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h10, 32'h0);
		burst(8, 1, 1'b1, 1'b0, 1'b0, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h80, 32'h0);
		burst(8, 1, 1'b0, 1'b0, 1'b1, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h86, 32'h0);
		burst(4, 2, 1'b1, 1'b0, 1'b0, 1'b1);
		wb(1'b1, ADR_CTRL, 32'h13, 32'h0);
		burst(8, 4, 1'b1, 1'b0, 1'b0, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h33, 32'h0);
		burst(8, 4, 1'b1, 1'b1, 1'b0, 1'b0);
		@(posedge clk_i);
		sgn <= 1'b0;
		addsub <= 1'b0;
		w18 <= 1'b1;
		rsrc <= 4'h0;
		wb(1'b1, ADR_CTRL, 32'h5, 32'h0);
		mac_step(1'b1, 1'b1, 4'h1, 1'b1);
		repeat (3) mac_step(1'b0, 1'b1, 4'h1, 1'b1);
		mac_step(1'b0, 1'b0, 4'h1, 1'b0);
		mac_step(1'b1, 1'b1, 4'h1, 1'b1);
		wb(1'b1, ADR_SEL, 32'h1000, 32'h0);
		mac_step(1'b0, 1'b1, 4'h1, 1'b0);
		mac_step(1'b0, 1'b1, 4'h2, 1'b1);
		@(posedge clk_i);
		rsrc <= 4'h1;
		expect_res('0, 2'b00);
		@(posedge clk_i);
		rsrc <= 4'h0;
		// subtracting start, then an unsigned add that wraps
		wb(1'b1, ADR_CTRL, 32'h85, 32'h0);
		drive_step(32'h3, 32'h3, 1'b1, 1'b1, 1'b0, 4'h2);
		expect_res({72'h0, -72'h9}, 2'b00);
		drive_step(32'h4, 32'h4, 1'b0, 1'b0, 1'b0, 4'h2);
		expect_res(144'h7, 2'b01);
		@(posedge clk_i);
		expect_res(144'h7, 2'b00);
		wb(1'b0, ADR_STAT, 32'h0, 32'h24);
		wb(1'b1, ADR_STAT, 32'h20, 32'h0);
		wb(1'b0, ADR_STAT, 32'h0, 32'h4);
		// input stage on: parallel load, then one serial shift
		w18 <= 1'b0;
		wb(1'b1, ADR_CTRL, 32'h180, 32'h0);
		drive_step(32'h87654321, 32'h12345678, 1'b0, 1'b0, 1'b0, 4'h1);
		@(posedge clk_i);
		expect_res(calc(32'h87654321, 32'h12345678, 1'b0, 1'b0, 8, 1),
			2'b00);
		drive_step(32'h9, 32'h2, 1'b0, 1'b0, 1'b1, 4'h1);
		@(posedge clk_i);
		expect_res(calc(32'h76543219, 32'h23456782, 1'b0, 1'b0, 8, 1),
			2'b00);
		repeat (4) @(posedge clk_i);
		report_and_stop();
	end
endmodule : test_dsp_multiply_accumulate_block
`default_nettype wire
